// File: src/gain_calib_pkg.sv
// Constants, types and field layout for the buffer gain and calibration registers
// Operation
// - Gain register at 0xA, bits 4:0 writable
// - Gain register bits 7:5 read zero
// - Code bit4 clear 1..0.2, set 10..1
// - Gain applies only when buffer in use
// - Calibration register at 0xB, bits 7:3 read-only
// - Calibration register bits 2:0 read zero
// - Calibration code loaded from OTP, part-specific
// - Slope is -(51 + code) LSB per kelvin
package gain_calib_pkg;

  localparam int unsigned ADDR_W        = 4;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned CODE_W        = 5;
  localparam int unsigned GAIN_W        = 10;
  localparam int unsigned SLOPE_W       = 7;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_BUFFER_GAIN = 4'ha;
  localparam logic [ADDR_W-1:0] OFS_TC_TRIM     = 4'hb;

  // Field positions
  localparam int unsigned GAIN_LSB      = 0;
  localparam int unsigned GAIN_MSB      = 4;
  localparam int unsigned TRIM_LSB      = 3;
  localparam int unsigned TRIM_MSB      = 7;
  localparam int unsigned RANGE_BIT     = 4;

  // Reset value of the gain field (gain 1 in the high range)
  localparam logic [CODE_W-1:0] GAIN_RESET  = 5'h1a;
  localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;

  // Slope magnitude at code 0, in LSB per kelvin
  localparam logic [SLOPE_W-1:0] SLOPE_BASE = 7'h33;

  // Gain times 100 when the buffer is bypassed
  localparam logic [GAIN_W-1:0] GAIN_UNITY  = 10'h064;
  localparam logic [GAIN_W-1:0] GAIN_NONE   = 10'h000;

  // One register access from the serial front end
  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
  } reg_req_type;

  // Analog-facing settings
  typedef struct packed {
    logic                  buffer_used;
    logic                  high_range;
    logic [GAIN_W-1:0]     gain_x100;
    logic [SLOPE_W-1:0]    slope_mag;
  } analog_cfg_type;

  // Gain times 100 for each code; codes without an entry give zero
  function automatic logic [GAIN_W-1:0] gain_x100_of(input logic [CODE_W-1:0] code);
    logic [GAIN_W-1:0] g;
    g = GAIN_NONE;
    case (code)
      5'h02:   g = 10'h064;
      5'h03:   g = 10'h043;
      5'h04:   g = 10'h032;
      5'h05:   g = 10'h028;
      5'h06:   g = 10'h021;
      5'h07:   g = 10'h01d;
      5'h08:   g = 10'h019;
      5'h09:   g = 10'h016;
      5'h0a:   g = 10'h014;
      5'h11:   g = 10'h3e8;
      5'h12:   g = 10'h1f4;
      5'h13:   g = 10'h14d;
      5'h14:   g = 10'h0fa;
      5'h15:   g = 10'h0c8;
      5'h16:   g = 10'h0a7;
      5'h17:   g = 10'h08f;
      5'h18:   g = 10'h07d;
      5'h19:   g = 10'h06f;
      5'h1a:   g = 10'h064;
      default: g = GAIN_NONE;
    endcase
    return g;
  endfunction

endpackage

// File: src/otp_trim_capture.sv
// Captures the one-time-programmed trim code after reset release
`timescale 1ns/10ps
module otp_trim_capture #(
  parameter int unsigned CODE_W = 5
) (
  input  wire logic              ref_clk,   // Device clock
  input  wire logic              resetn,    // Async reset, active low
  input  wire logic [CODE_W-1:0] otp_code,  // Fuse outputs, asynchronous
  output logic      [CODE_W-1:0] code_ff,   // Captured trim code
  output logic                   loaded_ff  // Code is valid
);

  logic [CODE_W-1:0] sync1_ff;
  logic [CODE_W-1:0] sync2_ff;
  logic [1:0]        settle_ff;
  logic [1:0]        nxt_settle;
  logic [CODE_W-1:0] nxt_code;
  logic              nxt_loaded;

  // Two-stage synchroniser on the fuse lines
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= otp_code;
      sync2_ff <= sync1_ff;
    end
  end

  // Wait for the synchroniser to fill, then take the code once
  always_comb
  begin
    nxt_settle = settle_ff;
    nxt_code   = code_ff;
    nxt_loaded = loaded_ff;
    if (!settle_ff[1])
    begin
      nxt_settle = {settle_ff[0], 1'b1};
    end
    else if (!loaded_ff)
    begin
      nxt_code   = sync2_ff;
      nxt_loaded = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      settle_ff <= '0;
      code_ff   <= '0;
      loaded_ff <= 1'b0;
    end
    else
    begin
      settle_ff <= nxt_settle;
      code_ff   <= nxt_code;
      loaded_ff <= nxt_loaded;
    end
  end

endmodule

// File: src/adc_gain_calib_registers.sv
// Buffer gain register and read-only bandgap/slope calibration register
`timescale 1ns/10ps
module adc_gain_calib_registers #(
  parameter int unsigned CODE_W = 5
) (
  input  wire logic                                 ref_clk,     // Device clock, 40 MHz
  input  wire logic                                 resetn,      // Power-on reset, active low
  input  wire gain_calib_pkg::reg_req_type          req,         // Register access, same clock
  input  wire logic                                 buffer_used, // Unity-gain bit selects buffer
  input  wire logic [CODE_W-1:0]                    otp_code,    // Fuse trim code, async
  output logic      [gain_calib_pkg::DATA_W-1:0]    rdata_ff,    // Read data, one cycle after rd
  output logic                                      rvalid_ff,   // Read data valid pulse
  output logic                                      trim_ready,  // Trim code captured
  output gain_calib_pkg::analog_cfg_type            cfg_ff       // Settings to analog blocks
);

  logic [CODE_W-1:0]                 gain_code_ff;
  logic [CODE_W-1:0]                 nxt_gain_code;
  logic [gain_calib_pkg::DATA_W-1:0] nxt_rdata;
  logic                              nxt_rvalid;
  gain_calib_pkg::analog_cfg_type    nxt_cfg;
  logic [CODE_W-1:0]                 trim_code;
  logic                              hit_gain;
  logic                              hit_trim;

  otp_trim_capture #(
    .CODE_W (CODE_W)
  ) u_trim (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .otp_code  (otp_code),
    .code_ff   (trim_code),
    .loaded_ff (trim_ready)
  );

  // Address decode
  assign hit_gain = (req.addr == gain_calib_pkg::OFS_BUFFER_GAIN);
  assign hit_trim = (req.addr == gain_calib_pkg::OFS_TC_TRIM);

  // Register writes; only the gain field holds state
  always_comb
  begin
    nxt_gain_code = gain_code_ff;
    if (req.wr && hit_gain)
    begin
      nxt_gain_code = req.wdata[gain_calib_pkg::GAIN_MSB:gain_calib_pkg::GAIN_LSB];
    end
    // other bits ignored
    // Upper gain bits and the whole trim register have no storage to write.
  end

  // Read path; unmapped offsets read as zero
  always_comb
  begin
    nxt_rdata  = rdata_ff;
    nxt_rvalid = req.rd;
    if (req.rd)
    begin
      nxt_rdata = gain_calib_pkg::DATA_ZERO;
      if (hit_gain)
      begin
        nxt_rdata[gain_calib_pkg::GAIN_MSB:gain_calib_pkg::GAIN_LSB] = gain_code_ff;
      end
      else if (hit_trim)
      begin
        nxt_rdata[gain_calib_pkg::TRIM_MSB:gain_calib_pkg::TRIM_LSB] = trim_code;
      end
    end
  end

  // Analog settings follow the registers one cycle later
  always_comb
  begin
    nxt_cfg             = '0;
    nxt_cfg.buffer_used = buffer_used;
    nxt_cfg.high_range  = gain_code_ff[gain_calib_pkg::RANGE_BIT];
    nxt_cfg.gain_x100   = buffer_used ? gain_calib_pkg::gain_x100_of(gain_code_ff)
                                      : gain_calib_pkg::GAIN_UNITY;
    nxt_cfg.slope_mag   = gain_calib_pkg::SLOPE_BASE
                        + {{(gain_calib_pkg::SLOPE_W-CODE_W){1'b0}}, trim_code};
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gain_code_ff <= gain_calib_pkg::GAIN_RESET;
      rdata_ff     <= gain_calib_pkg::DATA_ZERO;
      rvalid_ff    <= 1'b0;
      cfg_ff       <= '0;
    end
    else
    begin
      gain_code_ff <= nxt_gain_code;
      rdata_ff     <= nxt_rdata;
      rvalid_ff    <= nxt_rvalid;
      cfg_ff       <= nxt_cfg;
    end
  end

  // Checks; the read and config paths are one cycle behind their cause
  sequence s_gain_write;
    req.wr && hit_gain;
  endsequence

  sequence s_gain_read_next;
    req.rd && hit_gain && !req.wr;
  endsequence

  property p_gain_write;
    @(posedge ref_clk) disable iff (!resetn)
    s_gain_write |=>
      (gain_code_ff == $past(req.wdata[gain_calib_pkg::GAIN_MSB:gain_calib_pkg::GAIN_LSB]));
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("gain field did not take written value");

  // Write then read on the next cycle must already see the new code
  property p_gain_write_read;
    @(posedge ref_clk) disable iff (!resetn)
    s_gain_write ##1 s_gain_read_next |=>
      (rdata_ff[gain_calib_pkg::GAIN_MSB:gain_calib_pkg::GAIN_LSB]
       == $past(req.wdata[gain_calib_pkg::GAIN_MSB:gain_calib_pkg::GAIN_LSB], 2));
  endproperty
  a_gain_write_read: assert property (p_gain_write_read)
    else $error("gain readback differs from last write");

  property p_gain_high_zero;
    @(posedge ref_clk) disable iff (!resetn)
    (req.rd && hit_gain) |=>
      (rdata_ff[gain_calib_pkg::DATA_W-1:gain_calib_pkg::GAIN_MSB+1] == '0) && rvalid_ff;
  endproperty
  a_gain_high_zero: assert property (p_gain_high_zero)
    else $error("gain register upper bits not zero");

  // Low range never above unity, high range never below; unlisted codes give zero
  property p_range_bit;
    @(posedge ref_clk) disable iff (!resetn)
    buffer_used |=>
      (cfg_ff.high_range == $past(gain_code_ff[gain_calib_pkg::RANGE_BIT]))
      && (cfg_ff.high_range
          ? ((cfg_ff.gain_x100 >= gain_calib_pkg::GAIN_UNITY)
             || (cfg_ff.gain_x100 == gain_calib_pkg::GAIN_NONE))
          : (cfg_ff.gain_x100 <= gain_calib_pkg::GAIN_UNITY));
  endproperty
  a_range_bit: assert property (p_range_bit)
    else $error("gain range does not follow code bit 4");

  property p_bypass_unity;
    @(posedge ref_clk) disable iff (!resetn)
    !buffer_used |=> (cfg_ff.gain_x100 == gain_calib_pkg::GAIN_UNITY) && !cfg_ff.buffer_used;
  endproperty
  a_bypass_unity: assert property (p_bypass_unity)
    else $error("gain applied while buffer bypassed");

  // Buffer selection reaches the analog side one cycle later
  property p_buffer_copy;
    @(posedge ref_clk) disable iff (!resetn)
    1'b1 |=> (cfg_ff.buffer_used == $past(buffer_used));
  endproperty
  a_buffer_copy: assert property (p_buffer_copy)
    else $error("buffer selection not passed on");

  property p_trim_read;
    @(posedge ref_clk) disable iff (!resetn)
    (req.rd && hit_trim) |=>
      (rdata_ff[gain_calib_pkg::TRIM_MSB:gain_calib_pkg::TRIM_LSB] == $past(trim_code))
      && (rdata_ff[gain_calib_pkg::TRIM_LSB-1:0] == '0);
  endproperty
  a_trim_read: assert property (p_trim_read)
    else $error("trim register readback wrong");

  property p_trim_stable;
    @(posedge ref_clk) disable iff (!resetn)
    (trim_ready && req.wr && hit_trim) |=> $stable(trim_code);
  endproperty
  a_trim_stable: assert property (p_trim_stable)
    else $error("write changed read-only trim code");

  property p_trim_loaded;
    @(posedge ref_clk) disable iff (!resetn)
    $rose(trim_ready) |=> trim_ready [*8];
  endproperty
  a_trim_loaded: assert property (p_trim_loaded)
    else $error("trim capture dropped after load");

  property p_slope;
    @(posedge ref_clk) disable iff (!resetn)
    trim_ready ##1 $stable(trim_code) |->
      (cfg_ff.slope_mag == gain_calib_pkg::SLOPE_BASE
                           + {{(gain_calib_pkg::SLOPE_W-CODE_W){1'b0}}, $past(trim_code)});
  endproperty
  a_slope: assert property (p_slope)
    else $error("slope magnitude not 51 plus code");

  // Only a gain write may move the gain code
  property p_gain_hold;
    @(posedge ref_clk) disable iff (!resetn)
    !(req.wr && hit_gain) |=> $stable(gain_code_ff);
  endproperty
  a_gain_hold: assert property (p_gain_hold)
    else $error("gain code changed without a gain write");

  // Every read strobe gives exactly one valid pulse
  property p_read_pulse;
    @(posedge ref_clk) disable iff (!resetn)
    1'b1 |=> (rvalid_ff == $past(req.rd));
  endproperty
  a_read_pulse: assert property (p_read_pulse)
    else $error("read valid pulse does not follow read strobe");

  // Read data must hold between reads so a slow host still sees it
  property p_rdata_hold;
    @(posedge ref_clk) disable iff (!resetn)
    !req.rd |=> $stable(rdata_ff);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  // Trim code is fixed until the next reset once loaded
  property p_trim_fixed;
    @(posedge ref_clk) disable iff (!resetn)
    trim_ready |=> $stable(trim_code) && trim_ready;
  endproperty
  a_trim_fixed: assert property (p_trim_fixed)
    else $error("trim code moved after load");

endmodule

// File: testbench/host_model.sv
// Host model issuing register accesses to the gain and trim registers
`timescale 1ns/10ps
module host_model (
  input  wire logic                   ref_clk,    // Device clock
  output gain_calib_pkg::reg_req_type req,        // Register access
  output logic                        buffer_used // Unity-gain bit
);
  logic [7:0] exp_q[$];  // Expected read data, oldest first

  // Quiet bus at start
  initial
  begin
    req = '0;
    buffer_used = 1'b0;
  end

  // Unity-gain setting as the analog setup register would give it
  task automatic set_buffer(input logic v);
    buffer_used = v;
  endtask

  // Write then read the same offset on back-to-back cycles
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    @(negedge ref_clk);
    req = {1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    req = {1'b0, 1'b1, a, d};
    exp_q.push_back(e);
    @(negedge ref_clk);
    req = {2'h0, 4'($urandom), 8'($urandom)};
  endtask

  // One access per call, driven at the falling edge
  task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                        input logic [7:0] e);
    @(negedge ref_clk);
    req = {wr, ~wr, a, d};
    if (!wr)
      exp_q.push_back(e);
    @(negedge ref_clk);
    // Idle lines carry noise so no stale value passes for data
    req = {2'h0, 4'($urandom), 8'($urandom)};
  endtask
endmodule

// File: testbench/tb_adc_gain_calib_registers.sv
// Self-checking bench for the gain and calibration registers
`timescale 1ns/10ps
module tb_adc_gain_calib_registers;
  logic                           ref_clk;
  logic                           resetn;
  logic [4:0]                     otp_code;
  gain_calib_pkg::reg_req_type    req;
  logic                           buffer_used;
  logic [7:0]                     rdata_ff;
  logic                           rvalid_ff;
  logic                           trim_ready;
  gain_calib_pkg::analog_cfg_type cfg_ff;
  int                             error_cnt;
  int                             tests_run;
  // Gain times 100 per code, rounded; unlisted codes give zero
  logic [9:0] gain_tab [32] = '{10'h000, 10'h000, 10'h064, 10'h043, 10'h032, 10'h028,
    10'h021, 10'h01d, 10'h019, 10'h016, 10'h014, 10'h000, 10'h000, 10'h000, 10'h000,
    10'h000, 10'h000, 10'h3e8, 10'h1f4, 10'h14d, 10'h0fa, 10'h0c8, 10'h0a7, 10'h08f,
    10'h07d, 10'h06f, 10'h064, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000};

  host_model host (.ref_clk(ref_clk), .req(req), .buffer_used(buffer_used));

  adc_gain_calib_registers dut (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .req        (req),
    .buffer_used(buffer_used),
    .otp_code   (otp_code),
    .rdata_ff   (rdata_ff),
    .rvalid_ff  (rvalid_ff),
    .trim_ready (trim_ready),
    .cfg_ff     (cfg_ff)
  );

  // 40 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Bounded wait for the trim capture
  task automatic wait_trim();
    int n;
    n = 0;
    while (trim_ready !== 1'b1 && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 20)
    begin
      chk("trim_ready", 16'h0, 16'h1);
      end_sim();
    end
  endtask

  // Reset pulse, three cycles, then capture
  task automatic do_reset(input logic [4:0] code);
    resetn = 1'b0;
    otp_code = code;
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    wait_trim();
  endtask

  // Each read result is matched against the oldest note
  always @(negedge ref_clk)
    if (rvalid_ff === 1'b1)
    begin
      if (host.exp_q.size() == 0)
        chk("extra rvalid", 16'h1, 16'h0);
      else
        chk("rdata", rdata_ff, host.exp_q.pop_front());
    end

  initial
  begin
    logic       b;
    logic [4:0] k;
    error_cnt = 0;
    tests_run = 0;
    resetn = 1'b0;
    otp_code = 5'h15;
    void'($urandom(53976));
    do_reset(5'h15);
    host.access(1'b0, 4'ha, 8'h00, 8'h1a);
    host.access(1'b0, 4'hb, 8'h00, {otp_code, 3'h0});
    host.access(1'b0, 4'h3, 8'h00, 8'h00);
    $display("test reset values done");
    // Writes to unimplemented and read-only bits are dropped
    host.access(1'b1, 4'ha, 8'hff, 8'h00);
    host.access(1'b0, 4'ha, 8'h00, 8'h1f);
    host.access(1'b1, 4'hb, 8'hff, 8'h00);
    host.access(1'b0, 4'hb, 8'h00, {otp_code, 3'h0});
    $display("test write masks done");
    // Every gain code, buffer in use or bypassed at random
    for (int c = 0; c < 32; c++)
    begin
      b = 1'($urandom);
      host.set_buffer(b);
      // Random upper bits must be dropped on the back-to-back readback
      host.wr_rd(4'ha, {3'($urandom), 5'(c)}, {3'h0, 5'(c)});
      @(negedge ref_clk);
      chk("high_range", 16'(cfg_ff.high_range), 16'(c[4]));
      chk("gain", 16'(cfg_ff.gain_x100), 16'(b ? gain_tab[c] : 10'h064));
      chk("buf_used", 16'(cfg_ff.buffer_used), 16'(b));
    end
    $display("test gain sweep done");
    // Part-specific trim codes across resets, slope follows code
    for (int i = 0; i < 4; i++)
    begin
      k = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
      do_reset(k);
      host.access(1'b0, 4'ha, 8'h00, 8'h1a);
      host.access(1'b0, 4'hb, 8'h00, {k, 3'h0});
      chk("slope", 16'(cfg_ff.slope_mag), 16'(7'h33 + {2'h0, k}));
    end
    $display("test trim codes done");
    repeat (3) @(negedge ref_clk);
    chk("queue left", 16'(host.exp_q.size()), 16'h0);
    end_sim();
  end
endmodule
